//--- ifc_pkg.sv
// constants for the flag and clock-select block, with register offsets for channels 0 and 1
package ifc_pkg;
    localparam logic [27:0] IFC_FLAG_OFFSET_CH0 = 28'hffffd8a;
    localparam logic [27:0] IFC_FLAG_OFFSET_CH1 = 28'hffffd9a;
    localparam logic [31:0] IFC_CLK_OFFSET_CH0 = 32'hfffffd84;
    localparam logic [31:0] IFC_CLK_OFFSET_CH1 = 32'hfffffd94;
    localparam logic [7:0] IFC_RESET_VAL = 8'h00;
    // flag register fields
    localparam int IFC_F_RSV = 0;
    localparam int IFC_F_STCEN = 1;
    localparam int IFC_F_BUSY = 6;
    localparam int IFC_F_SFAIL = 7;
    // clock select fields
    localparam int IFC_C_DIV_LO = 0;
    localparam int IFC_C_DIV_HI = 1;
    localparam int IFC_C_FILT = 2;
    localparam int IFC_C_SMC = 3;
    localparam int IFC_C_SDA = 4;
    localparam int IFC_C_SCL = 5;
    localparam logic [7:0] IFC_C_WMASK = 8'h0f;
    // noise filter length in cycles
    localparam logic [1:0] IFC_FILT_LEN = 2'h3;
    typedef enum logic [1:0] {
        IFC_IDLE = 2'b00,
        IFC_BUSY = 2'b01,
        IFC_WAIT = 2'b11
    } ifc_state_t;
endpackage : ifc_pkg

//--- ifc_flag_clk.sv
// flag and clock-select registers of one bus channel
// Function
// - byte or bit access; fail and busy flags read-only, writes ignored
// - reservation and initial-start bits writable only while disabled
// - reset clears both registers
// - failed start with reservation off clears trigger and sets fail flag
// - fail flag cleared by trigger set, disable, or reset
// - busy reads 0 when released, 1 during traffic; enable value per initial-start
// - busy set by start or enable without initial-start; cleared by stop or disable
// - initial-start set by software, cleared by start detect and reset
// - reservation-disable set only by software, cleared by software and reset
// - level monitors read-only; mode, expansion bit, divider choose transfer clock
// - scl monitor follows pin while enabled, 0 while disabled
// - sda monitor follows pin while enabled, 0 while disabled
// - mode bit 0 standard, 1 high speed
// - filter bit turns on input noise filter, high speed only
// - filter setting does not change transfer clock in high speed
// - expansion bit acts only in high speed mode
module ifc_flag_clk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic operation_enable,
    input wire logic start_trigger_set,
    input wire logic start_gen_failed,
    input wire logic start_detected,
    input wire logic stop_detected,
    input wire logic scl_pin,
    input wire logic sda_pin,
    input wire logic expansion_clock_bit,
    input wire logic flag_wr,
    input wire logic clk_wr,
    input wire logic [7:0] wr_mask,
    input wire logic [7:0] wr_data,
    output logic [7:0] bus_flag_reg,
    output logic [7:0] clock_select_reg,
    output logic start_trigger_clear,
    output logic start_allowed,
    output logic speed_mode_select,
    output logic [2:0] clock_sel_code,
    output logic filt_scl,
    output logic filt_sda
);
    logic rsv_reg, rsv_next;
    logic stcen_reg, stcen_next;
    logic fail_reg, fail_next;
    logic en_d_reg, en_d_next;
    logic [3:0] clk_reg, clk_next;
    logic scl_mon_reg, scl_mon_next;
    logic sda_mon_reg, sda_mon_next;
    logic clr_reg, clr_next;
    logic [1:0] scl_cnt_reg, scl_cnt_next, sda_cnt_reg, sda_cnt_next;
    logic fscl_reg, fscl_next, fsda_reg, fsda_next;
    ifc_pkg::ifc_state_t st_reg, st_next;
    logic filt_on;

    // masked single-bit merge
    function automatic logic merge(input logic old, input logic m, input logic d);
        merge = m ? d : old;
    endfunction : merge

    // bus state: busy and start permission
    always_comb begin
        st_next = st_reg;
        if (!operation_enable) begin
            st_next = ifc_pkg::IFC_IDLE;
        end else if (!en_d_reg) begin
            st_next = stcen_reg ? ifc_pkg::IFC_IDLE : ifc_pkg::IFC_WAIT;
        end else begin
            case (st_reg)
                ifc_pkg::IFC_IDLE: begin
                    if (start_detected) st_next = ifc_pkg::IFC_BUSY;
                end
                ifc_pkg::IFC_BUSY, ifc_pkg::IFC_WAIT: begin
                    if (stop_detected) st_next = ifc_pkg::IFC_IDLE;
                    else if (start_detected) st_next = ifc_pkg::IFC_BUSY;
                end
                default: st_next = ifc_pkg::IFC_IDLE;
            endcase
        end
    end

    // flag register bits
    always_comb begin
        en_d_next = operation_enable;
        rsv_next = rsv_reg;
        stcen_next = stcen_reg;
        fail_next = fail_reg;
        clr_next = 1'b0;
        // config bits only take writes while disabled
        if (flag_wr && !operation_enable) begin
            rsv_next = merge(rsv_reg, wr_mask[ifc_pkg::IFC_F_RSV],
                wr_data[ifc_pkg::IFC_F_RSV]);
            stcen_next = merge(stcen_reg, wr_mask[ifc_pkg::IFC_F_STCEN],
                wr_data[ifc_pkg::IFC_F_STCEN]);
        end
        if (start_detected) stcen_next = 1'b0;
        if (rsv_reg && start_gen_failed && operation_enable) begin
            fail_next = 1'b1;
            clr_next = 1'b1;
        end else if (start_trigger_set || !operation_enable) begin
            fail_next = 1'b0;
        end
    end

    // clock select and pin monitors
    always_comb begin
        clk_next = clk_reg;
        if (clk_wr && !operation_enable) begin
            clk_next = (clk_reg & ~wr_mask[3:0]) | (wr_data[3:0] & wr_mask[3:0]);
        end
        scl_mon_next = operation_enable & scl_pin;
        sda_mon_next = operation_enable & sda_pin;
    end

    // noise filter: level must hold a few cycles; bypassed when off
    assign filt_on = clk_reg[ifc_pkg::IFC_C_FILT] & clk_reg[ifc_pkg::IFC_C_SMC];
    always_comb begin
        scl_cnt_next = 2'h0;
        sda_cnt_next = 2'h0;
        fscl_next = fscl_reg;
        fsda_next = fsda_reg;
        if (!filt_on) begin
            fscl_next = scl_pin;
            fsda_next = sda_pin;
        end else begin
            // counter restarts once a level is taken, so the next edge waits the full length
            if (scl_pin != fscl_reg) begin
                if (scl_cnt_reg == ifc_pkg::IFC_FILT_LEN - 2'h1) begin
                    fscl_next = scl_pin;
                end else begin
                    scl_cnt_next = scl_cnt_reg + 2'h1;
                end
            end
            if (sda_pin != fsda_reg) begin
                if (sda_cnt_reg == ifc_pkg::IFC_FILT_LEN - 2'h1) begin
                    fsda_next = sda_pin;
                end else begin
                    sda_cnt_next = sda_cnt_reg + 2'h1;
                end
            end
        end
    end

    // bus state register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_reg <= ifc_pkg::IFC_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // flag register bits and trigger clear pulse
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rsv_reg <= 1'b0;
            stcen_reg <= 1'b0;
            fail_reg <= 1'b0;
            en_d_reg <= 1'b0;
            clr_reg <= 1'b0;
        end else begin
            rsv_reg <= rsv_next;
            stcen_reg <= stcen_next;
            fail_reg <= fail_next;
            en_d_reg <= en_d_next;
            clr_reg <= clr_next;
        end
    end

    // clock select bits and pin monitors
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            clk_reg <= 4'h0;
            scl_mon_reg <= 1'b0;
            sda_mon_reg <= 1'b0;
        end else begin
            clk_reg <= clk_next;
            scl_mon_reg <= scl_mon_next;
            sda_mon_reg <= sda_mon_next;
        end
    end

    // filter state; outputs start at the released bus level
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            scl_cnt_reg <= 2'h0;
            sda_cnt_reg <= 2'h0;
            fscl_reg <= 1'b1;
            fsda_reg <= 1'b1;
        end else begin
            scl_cnt_reg <= scl_cnt_next;
            sda_cnt_reg <= sda_cnt_next;
            fscl_reg <= fscl_next;
            fsda_reg <= fsda_next;
        end
    end

    // read views; unused bits tie low
    always_comb begin
        bus_flag_reg = ifc_pkg::IFC_RESET_VAL;
        bus_flag_reg[ifc_pkg::IFC_F_SFAIL] = fail_reg;
        bus_flag_reg[ifc_pkg::IFC_F_BUSY] = (st_reg != ifc_pkg::IFC_IDLE);
        bus_flag_reg[ifc_pkg::IFC_F_STCEN] = stcen_reg;
        bus_flag_reg[ifc_pkg::IFC_F_RSV] = rsv_reg;
        clock_select_reg = {4'h0, clk_reg} & ifc_pkg::IFC_C_WMASK;
        clock_select_reg[ifc_pkg::IFC_C_SCL] = scl_mon_reg;
        clock_select_reg[ifc_pkg::IFC_C_SDA] = sda_mon_reg;
    end

    assign start_trigger_clear = clr_reg;
    assign start_allowed = operation_enable & en_d_reg & (st_reg != ifc_pkg::IFC_WAIT);
    assign speed_mode_select = clk_reg[ifc_pkg::IFC_C_SMC];
    // filter bit deliberately excluded so clock is unchanged by it
    assign clock_sel_code = {expansion_clock_bit & clk_reg[ifc_pkg::IFC_C_SMC],
        clk_reg[ifc_pkg::IFC_C_DIV_HI], clk_reg[ifc_pkg::IFC_C_DIV_LO]};
    assign filt_scl = fscl_reg;
    assign filt_sda = fsda_reg;

    busy_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !operation_enable |=> !bus_flag_reg[ifc_pkg::IFC_F_BUSY])
        else $error("busy flag not cleared while disabled");
    busy_enable_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (operation_enable && !en_d_reg && !stcen_reg) |=> bus_flag_reg[ifc_pkg::IFC_F_BUSY])
        else $error("busy flag not set on enable");
    fail_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rsv_reg && start_gen_failed && operation_enable) |=> fail_reg && start_trigger_clear)
        else $error("failed start not flagged");
    fail_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!operation_enable) |=> !fail_reg)
        else $error("fail flag not cleared");
    stcen_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        start_detected |=> !stcen_reg)
        else $error("initial start not cleared on start");
    cfg_lock_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (operation_enable && $past(operation_enable)) |-> $stable(rsv_reg) && $stable(clk_reg))
        else $error("config changed while enabled");
    scl_mon_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> clock_select_reg[ifc_pkg::IFC_C_SCL] == ($past(operation_enable) & $past(scl_pin)))
        else $error("scl monitor wrong");
    sda_mon_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> clock_select_reg[ifc_pkg::IFC_C_SDA] == ($past(operation_enable) & $past(sda_pin)))
        else $error("sda monitor wrong");
    unused_zero_a: assert property (@(posedge core_clk)
        bus_flag_reg[5:2] == 4'h0 && clock_select_reg[7:6] == 2'h0)
        else $error("unused bits not zero");

    // reset and register write checks
    reset_zero_a: assert property (@(posedge core_clk)
        !rst_n |=> bus_flag_reg == ifc_pkg::IFC_RESET_VAL && clock_select_reg == 8'h00)
        else $error("registers not zero after reset");
    rsv_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (flag_wr && !operation_enable && wr_mask[ifc_pkg::IFC_F_RSV]) |=> rsv_reg == $past(wr_data[ifc_pkg::IFC_F_RSV]))
        else $error("reservation bit write lost");
    rsv_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!flag_wr || operation_enable) |=> $stable(rsv_reg))
        else $error("reservation bit changed without write");
    stcen_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (flag_wr && !operation_enable && wr_mask[ifc_pkg::IFC_F_STCEN] && !start_detected) |=> stcen_reg == $past(wr_data[ifc_pkg::IFC_F_STCEN]))
        else $error("initial start write lost");
    stcen_lock_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (operation_enable && $past(operation_enable) && !$past(start_detected)) |-> $stable(stcen_reg))
        else $error("initial start changed while enabled");
    mode_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clk_wr && !operation_enable && wr_mask[ifc_pkg::IFC_C_SMC]) |=> speed_mode_select == $past(wr_data[ifc_pkg::IFC_C_SMC]))
        else $error("mode bit write lost");

    // failed start flag checks
    fail_readonly_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (flag_wr && operation_enable && !start_gen_failed && !start_trigger_set) |=> $stable(fail_reg))
        else $error("fail flag changed by write");
    fail_prio_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rsv_reg && start_gen_failed && operation_enable && start_trigger_set) |=> fail_reg)
        else $error("fail set lost to trigger clear");
    fail_trig_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (start_trigger_set && !(rsv_reg && start_gen_failed && operation_enable)) |=> !fail_reg)
        else $error("fail flag not cleared by trigger");
    fail_rsv_only_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!rsv_reg && !fail_reg) |=> !fail_reg)
        else $error("fail flag set with reservation on");
    clr_with_fail_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        start_trigger_clear |-> fail_reg)
        else $error("trigger clear without fail flag");
    clr_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (start_trigger_clear && !start_gen_failed) |=> !start_trigger_clear)
        else $error("trigger clear longer than one cycle");

    // bus busy and start permission checks
    busy_start_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (operation_enable && en_d_reg && start_detected && !stop_detected) |=> bus_flag_reg[ifc_pkg::IFC_F_BUSY])
        else $error("busy not set on start");
    busy_stop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (operation_enable && en_d_reg && stop_detected && !start_detected) |=> !bus_flag_reg[ifc_pkg::IFC_F_BUSY])
        else $error("busy not cleared on stop");
    busy_init_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (operation_enable && !en_d_reg && stcen_reg) |=> !bus_flag_reg[ifc_pkg::IFC_F_BUSY])
        else $error("busy set despite initial start");
    allow_wait_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (operation_enable && !en_d_reg && !stcen_reg) |=> !start_allowed)
        else $error("start allowed before stop");
    allow_stop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (operation_enable && en_d_reg && stop_detected) |=> (!operation_enable || start_allowed))
        else $error("start not allowed after stop");

    // clock code and filter checks
    exp_std_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !speed_mode_select |-> !clock_sel_code[2])
        else $error("expansion bit active in standard mode");
    filt_bypass_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !filt_on |=> filt_scl == $past(scl_pin) && filt_sda == $past(sda_pin))
        else $error("filter not bypassed");
    filt_scl_glitch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (filt_on && scl_cnt_reg == 2'h0 && scl_pin != fscl_reg) |=> filt_scl == $past(fscl_reg))
        else $error("scl glitch passed filter");
    filt_sda_glitch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (filt_on && sda_cnt_reg == 2'h0 && sda_pin != fsda_reg) |=> filt_sda == $past(fsda_reg))
        else $error("sda glitch passed filter");
endmodule : ifc_flag_clk

//--- ifc_bus_peer.sv
// model of another bus master sharing scl and sda with the channel
module ifc_bus_peer (
    input wire logic core_clk,
    output logic scl_pin,
    output logic sda_pin,
    output logic start_detected,
    output logic stop_detected
);
    timeunit 1ns;
    timeprecision 1ps;
    // released lines sit high through the pull-ups
    initial begin
        scl_pin = 1'b1;
        sda_pin = 1'b1;
        start_detected = 1'b0;
        stop_detected = 1'b0;
    end
    // sda falls with scl high, only from an idle bus
    task automatic start_cond();
        wait (scl_pin && sda_pin);
        sda_pin = 1'b0;
        start_detected = 1'b1;
        @(posedge core_clk) #1;
        start_detected = 1'b0;
    endtask : start_cond
    // sda rises with scl high, releasing the bus
    task automatic stop_cond();
        sda_pin = 1'b0;
        @(posedge core_clk) #1;
        sda_pin = 1'b1;
        stop_detected = 1'b1;
        @(posedge core_clk) #1;
        stop_detected = 1'b0;
    endtask : stop_cond
    // short pull on one line, as noise would make; both lines released after
    task automatic glitch(input logic on_scl, input int n);
        if (on_scl) begin
            scl_pin = 1'b0;
        end else begin
            sda_pin = 1'b0;
        end
        repeat (n) @(posedge core_clk);
        #1;
        scl_pin = 1'b1;
        sda_pin = 1'b1;
    endtask : glitch
endmodule : ifc_bus_peer

//--- testbench.sv
// self-checking bench for the flag and clock-select block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic operation_enable = 1'b0;
    logic start_trigger_set = 1'b0;
    logic start_gen_failed = 1'b0;
    logic expansion_clock_bit = 1'b0;
    logic flag_wr = 1'b0;
    logic clk_wr = 1'b0;
    logic [7:0] wr_mask = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic scl_pin, sda_pin, start_detected, stop_detected, seen;
    logic [7:0] bus_flag_reg, clock_select_reg;
    logic start_trigger_clear, start_allowed, speed_mode_select;
    logic [2:0] clock_sel_code;
    logic filt_scl, filt_sda;
    int err_total = 0;
    int n_tests = 0;
    // 25 MHz core clock
    always #20 core_clk = ~core_clk;
    ifc_bus_peer peer (.core_clk(core_clk), .scl_pin(scl_pin), .sda_pin(sda_pin),
        .start_detected(start_detected), .stop_detected(stop_detected));
    ifc_flag_clk DUT (.core_clk(core_clk), .rst_n(rst_n),
        .operation_enable(operation_enable), .start_trigger_set(start_trigger_set),
        .start_gen_failed(start_gen_failed), .start_detected(start_detected),
        .stop_detected(stop_detected), .scl_pin(scl_pin), .sda_pin(sda_pin),
        .expansion_clock_bit(expansion_clock_bit), .flag_wr(flag_wr), .clk_wr(clk_wr),
        .wr_mask(wr_mask), .wr_data(wr_data), .bus_flag_reg(bus_flag_reg),
        .clock_select_reg(clock_select_reg), .start_trigger_clear(start_trigger_clear),
        .start_allowed(start_allowed), .speed_mode_select(speed_mode_select),
        .clock_sel_code(clock_sel_code), .filt_scl(filt_scl), .filt_sda(filt_sda));
    // step n edges, then drive 1 ns later
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one-cycle write strobe to either register, then one settling edge
    task automatic wr(input logic is_clk, input logic [7:0] m, input logic [7:0] d);
        flag_wr = ~is_clk;
        clk_wr = is_clk;
        wr_mask = m;
        wr_data = d;
        cyc(1);
        flag_wr = 1'b0;
        clk_wr = 1'b0;
        cyc(1);
    endtask : wr
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    // run is about 60 cycles; a hang is cut well after that
    initial begin
        #20us;
        err_total++;
        give_verdict();
    end
    // main sequence
    initial begin
        cyc(6);
        rst_n = 1'b1;
        chk(bus_flag_reg, 8'h00);
        chk(clock_select_reg, 8'h00);
        wr(1'b0, 8'h01, 8'h01);
        chk(bus_flag_reg, 8'h01);
        wr(1'b0, 8'hff, 8'hff);
        chk(bus_flag_reg, 8'h03);
        wr(1'b1, 8'hff, 8'hff);
        chk(clock_select_reg, 8'h0f);
        chk({5'h00, clock_sel_code}, 8'h03);
        expansion_clock_bit = 1'b1;
        cyc(2);
        chk({5'h00, clock_sel_code}, 8'h07);
        wr(1'b1, 8'h04, 8'h00);
        chk({7'h00, speed_mode_select}, 8'h01);
        chk({5'h00, clock_sel_code}, 8'h07);
        operation_enable = 1'b1;
        cyc(3);
        chk(bus_flag_reg, 8'h03);
        chk({7'h00, start_allowed}, 8'h01);
        chk(clock_select_reg, 8'h3b);
        wr(1'b0, 8'hff, 8'h00);
        chk(bus_flag_reg, 8'h03);
        peer.start_cond();
        cyc(2);
        chk(bus_flag_reg, 8'h41);
        chk(clock_select_reg, 8'h2b);
        start_gen_failed = 1'b1;
        cyc(1);
        start_gen_failed = 1'b0;
        seen = start_trigger_clear;
        cyc(1);
        seen = seen | start_trigger_clear;
        chk({7'h00, seen}, 8'h01);
        chk(bus_flag_reg, 8'hc1);
        start_trigger_set = 1'b1;
        cyc(1);
        start_trigger_set = 1'b0;
        cyc(1);
        chk(bus_flag_reg, 8'h41);
        peer.stop_cond();
        cyc(1);
        chk(bus_flag_reg, 8'h01);
        start_gen_failed = 1'b1;
        cyc(1);
        start_gen_failed = 1'b0;
        cyc(1);
        operation_enable = 1'b0;
        cyc(3);
        chk(bus_flag_reg, 8'h01);
        chk(clock_select_reg, 8'h0b);
        operation_enable = 1'b1;
        cyc(3);
        chk(bus_flag_reg, 8'h41);
        chk({7'h00, start_allowed}, 8'h00);
        peer.stop_cond();
        cyc(1);
        chk(bus_flag_reg, 8'h01);
        chk({7'h00, start_allowed}, 8'h01);
        operation_enable = 1'b0;
        cyc(2);
        wr(1'b0, 8'h01, 8'h00);
        chk(bus_flag_reg, 8'h00);
        wr(1'b1, 8'h08, 8'h00);
        chk({5'h00, clock_sel_code}, 8'h03);
        chk({7'h00, speed_mode_select}, 8'h00);
        wr(1'b1, 8'h04, 8'h04);
        peer.glitch(1'b0, 1);
        chk({7'h00, filt_sda}, 8'h00);
        wr(1'b1, 8'h08, 8'h08);
        peer.glitch(1'b0, 2);
        chk({7'h00, filt_sda}, 8'h01);
        cyc(1);
        peer.glitch(1'b1, 3);
        chk({7'h00, filt_scl}, 8'h00);
        cyc(3);
        chk({7'h00, filt_scl}, 8'h01);
        give_verdict();
    end
endmodule : testbench
